// [logic/pxa_top.sv]
/*
  port expander serial slave with address select decode, power-up
  defaults, pullup selection and latched input change detection.
  assumes a classic wishbone master on CLK, and a two-wire bus, select
  pins and port pins that arrive from outside the clock domain.
*/
`include "pxa_cfg.svh"
module pxa_top import pxa_pkg::*; #(
  parameter int NPORT = 8
) (
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             ARST_N,
  // wishbone slave
  input  wire logic             CYC_I,
  input  wire logic             STB_I,
  input  wire logic             WE_I,
  input  wire logic [7:0]       ADR_I,
  input  wire logic [3:0]       SEL_I,
  input  wire logic [31:0]      DAT_I,
  output logic      [31:0]      DAT_O,
  output logic                  ACK_O,
  // two-wire bus
  input  wire logic             SCL_I,
  input  wire logic             SDA_I,
  output logic                  SDA_O,
  output logic                  SDA_OE,
  input  wire logic             BUS_RST_N,
  // address select pins
  input  wire logic             ADDR_SELECT_LOW_PIN,
  input  wire logic             ADDR_SELECT_HIGH_PIN,
  // ports
  input  wire logic [NPORT-1:0] OPEN_DRAIN_IO_PORTS_I,
  output logic      [NPORT-1:0] OPEN_DRAIN_IO_PORTS_O,
  output logic      [NPORT-1:0] OPEN_DRAIN_IO_PORTS_OE,
  output logic      [NPORT-1:0] PUSH_PULL_OUTPUTS,
  input  wire logic [NPORT-1:0] PUSH_PULL_READBACK,
  output logic      [NPORT-1:0] PULLUP_EN,
  // status
  output logic                  INT_N,
  output logic                  STANDBY
);
  // =====================================================================
  // elaboration check
  if (NPORT != 8) begin : g_chk
    $error("pxa_top serves exactly eight ports per group");
  end

  // =====================================================================
  // helpers
  function automatic pxa_sel_type sel_decode(logic pre, logic at_start, logic at_fall);
    pxa_sel_type s;
    if (!pre) s = PXA_SEL_LOW;            // low in the sample before start
    else if (!at_start) s = PXA_SEL_SDA;  // follows the data line down
    else if (!at_fall) s = PXA_SEL_SCL;   // follows the clock line down
    else s = PXA_SEL_HIGH;
    return s;
  endfunction

  function automatic logic [3:0] low_bits(pxa_selpair_type s);
    logic [1:0] h;
    logic [1:0] l;
    unique case (s.hi)
      PXA_SEL_SCL:  h = 2'h0;
      PXA_SEL_SDA:  h = 2'h1;
      PXA_SEL_LOW:  h = 2'h2;
      PXA_SEL_HIGH: h = 2'h3;
    endcase
    unique case (s.lo)
      PXA_SEL_LOW:  l = 2'h0;
      PXA_SEL_HIGH: l = 2'h1;
      PXA_SEL_SCL:  l = 2'h2;
      PXA_SEL_SDA:  l = 2'h3;
    endcase
    return {h, l};
  endfunction

  function automatic logic [7:0] group_level(pxa_selpair_type s);
    return {{4{s.hi != PXA_SEL_LOW}}, {4{s.lo != PXA_SEL_LOW}}};
  endfunction

  // =====================================================================
  // reset release and input synchronisers
  logic [1:0]   rst_sync_r;
  logic         rst_n;
  logic [20:0]  syn;
  logic         scl;
  logic         sda;
  logic         bus_rst_n;
  logic [1:0]   sel_pin;
  logic [7:0]   rb_live;
  logic [7:0]   io_live;

  // asynchronous assert, two-flop release
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  pxa_sync #(.W(21)) u_sync (
    .clk    (CLK),
    .arst_n (rst_n),
    .d      ({SCL_I, SDA_I, BUS_RST_N, ADDR_SELECT_HIGH_PIN, ADDR_SELECT_LOW_PIN,
              PUSH_PULL_READBACK, OPEN_DRAIN_IO_PORTS_I}),
    .q      (syn)
  );
  assign {scl, sda, bus_rst_n, sel_pin, rb_live, io_live} = syn;

  // =====================================================================
  // bus condition detect
  logic         scl_q_r;
  logic         sda_q_r;
  logic [1:0]   sel_q_r;
  logic         start;
  logic         stop;
  logic         rise;
  logic         fall;
  logic         ctrl_en_r;
  logic         link_ok;

  // previous sampled line levels
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      sel_q_r <= 2'h3;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      sel_q_r <= sel_pin;
    end
  end
  assign start   = scl & scl_q_r & sda_q_r & ~sda;
  assign stop    = scl & scl_q_r & ~sda_q_r & sda;
  assign rise    = scl & ~scl_q_r;
  assign fall    = ~scl & scl_q_r;
  assign link_ok = bus_rst_n & ctrl_en_r;

  // =====================================================================
  // serial interface, select decode and port latches
  pxa_state_type   state_r, state_nxt;
  logic [3:0]      cnt_r, cnt_nxt;
  logic [7:0]      sh_r, sh_nxt;
  logic            rw_r, rw_nxt;
  logic            grp_io_r, grp_io_nxt;
  logic            bsel_r, bsel_nxt;
  logic            sda_oe_r, sda_oe_nxt;
  logic            pend_r, pend_nxt;
  logic [1:0]      pre_r, pre_nxt;
  logic [1:0]      st_r, st_nxt;
  pxa_selpair_type sel_r, sel_nxt;
  pxa_selpair_type dec;
  logic            done_r, done_nxt;
  logic [1:0]      strap_r, strap_nxt;
  logic [7:0]      io_lat_r, io_lat_nxt;
  logic [7:0]      pp_lat_r, pp_lat_nxt;
  logic [7:0]      pull_r, pull_nxt;
  logic            rd_act_r, rd_act_nxt;
  logic            standby_r;
  logic            ack_evt;
  logic            wr_io;
  logic [6:0]      io_addr;
  logic [6:0]      pp_addr;
  logic [7:0]      snap_r;
  logic [7:0]      hold_r;

  assign io_addr = {`PXA_IO_PREFIX, low_bits(sel_r)};
  assign pp_addr = {`PXA_PP_PREFIX, low_bits(sel_r)};
  assign dec.hi  = sel_decode(pre_r[1], st_r[1], sel_pin[1]);
  assign dec.lo  = sel_decode(pre_r[0], st_r[0], sel_pin[0]);

  // next state of the serial side
  always_comb begin
    state_nxt = state_r;   cnt_nxt = cnt_r;       sh_nxt = sh_r;
    rw_nxt = rw_r;         grp_io_nxt = grp_io_r; bsel_nxt = bsel_r;
    sda_oe_nxt = sda_oe_r; pend_nxt = pend_r;     pre_nxt = pre_r;
    st_nxt = st_r;         sel_nxt = sel_r;       done_nxt = done_r;
    strap_nxt = strap_r;   io_lat_nxt = io_lat_r; pp_lat_nxt = pp_lat_r;
    pull_nxt = pull_r;     rd_act_nxt = rd_act_r;
    ack_evt = 1'b0;
    wr_io = 1'b0;
    // power-up: pins read only as high or low until a transmission
    if (strap_r != `PXA_STRAP_WAIT) begin
      strap_nxt = strap_r + 2'h1;
      if (strap_r == `PXA_STRAP_WAIT - 2'h1) begin
        sel_nxt.hi = sel_pin[1] ? PXA_SEL_HIGH : PXA_SEL_LOW;
        sel_nxt.lo = sel_pin[0] ? PXA_SEL_HIGH : PXA_SEL_LOW;
        pull_nxt   = group_level(sel_nxt);
        io_lat_nxt = group_level(sel_nxt);
        pp_lat_nxt = group_level(sel_nxt);
      end
    end
    if (!link_ok) begin
      state_nxt  = PXA_IDLE;
      sda_oe_nxt = 1'b0;
      pend_nxt   = 1'b0;
      rd_act_nxt = 1'b0;
    end else if (start) begin
      state_nxt  = PXA_ADDR;
      cnt_nxt    = 4'h0;
      sda_oe_nxt = 1'b0;
      pend_nxt   = 1'b1;
      pre_nxt    = sel_q_r;
      st_nxt     = sel_pin;
    end else if (stop) begin
      state_nxt  = PXA_IDLE;
      sda_oe_nxt = 1'b0;
      rd_act_nxt = 1'b0;
    end else begin
      // first clock fall of every transmission completes the decode
      if (pend_r && fall) begin
        pend_nxt = 1'b0;
        sel_nxt  = dec;
        if (!done_r) begin
          done_nxt   = 1'b1;
          pull_nxt   = group_level(dec);
          io_lat_nxt = group_level(dec);
          pp_lat_nxt = group_level(dec);
        end
      end
      unique case (state_r)
        PXA_IDLE, PXA_SKIP: ;
        PXA_ADDR, PXA_WR: begin
          if (rise) begin
            sh_nxt  = {sh_r[6:0], sda};
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == `PXA_BYTE_BITS) begin
            if (state_r == PXA_WR) begin
              state_nxt  = PXA_WACK;
              sda_oe_nxt = 1'b1;
              if (grp_io_r) begin
                io_lat_nxt = sh_r;
                wr_io      = 1'b1;
              end else pp_lat_nxt = sh_r;
            end else if (sh_r[7:1] == io_addr || sh_r[7:1] == pp_addr) begin
              state_nxt  = PXA_AACK;
              sda_oe_nxt = 1'b1;
              grp_io_nxt = (sh_r[7:1] == io_addr);
              rw_nxt     = sh_r[0];
            end else state_nxt = PXA_SKIP;
          end
        end
        PXA_AACK: begin
          if (rise) ack_evt = 1'b1;
          else if (fall) begin
            cnt_nxt = 4'h0;
            if (rw_r) begin
              state_nxt  = PXA_RD;
              sh_nxt     = grp_io_r ? snap_r : rb_live;
              sda_oe_nxt = grp_io_r ? ~snap_r[7] : ~rb_live[7];
              bsel_nxt   = 1'b1;
              rd_act_nxt = grp_io_r;
            end else begin
              state_nxt  = PXA_WR;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        PXA_WACK: begin
          if (fall) begin
            state_nxt  = PXA_WR;
            sda_oe_nxt = 1'b0;
            cnt_nxt    = 4'h0;
          end
        end
        PXA_RD: begin
          if (fall) begin
            if (cnt_r == `PXA_BYTE_BITS - 4'h1) begin
              state_nxt  = PXA_RACK;
              sda_oe_nxt = 1'b0;
            end else begin
              sh_nxt     = {sh_r[6:0], 1'b0};
              sda_oe_nxt = ~sh_r[6];
              cnt_nxt    = cnt_r + 4'h1;
            end
          end
        end
        PXA_RACK: begin
          if (rise) begin
            if (sda) state_nxt = PXA_SKIP;
            else if (grp_io_r && !bsel_r) ack_evt = 1'b1;
          end else if (fall) begin
            state_nxt = PXA_RD;
            cnt_nxt   = 4'h0;
            if (grp_io_r) begin
              sh_nxt     = bsel_r ? hold_r : snap_r;
              sda_oe_nxt = bsel_r ? ~hold_r[7] : ~snap_r[7];
              bsel_nxt   = ~bsel_r;
            end else begin
              sh_nxt     = rb_live;
              sda_oe_nxt = ~rb_live[7];
            end
          end
        end
      endcase
    end
  end

  // serial side registers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PXA_IDLE; cnt_r <= 4'h0;    sh_r <= 8'h00;
      rw_r <= 1'b0;        grp_io_r <= 1'b0; bsel_r <= 1'b0;
      sda_oe_r <= 1'b0;    pend_r <= 1'b0;   pre_r <= 2'h3;
      st_r <= 2'h3;        done_r <= 1'b0;   strap_r <= 2'h0;
      sel_r <= '{hi: PXA_SEL_HIGH, lo: PXA_SEL_HIGH};
      io_lat_r <= 8'hFF;   pp_lat_r <= 8'hFF; pull_r <= 8'hFF;
      rd_act_r <= 1'b0;    standby_r <= 1'b1;
    end else begin
      state_r <= state_nxt;   cnt_r <= cnt_nxt;       sh_r <= sh_nxt;
      rw_r <= rw_nxt;         grp_io_r <= grp_io_nxt; bsel_r <= bsel_nxt;
      sda_oe_r <= sda_oe_nxt; pend_r <= pend_nxt;     pre_r <= pre_nxt;
      st_r <= st_nxt;         sel_r <= sel_nxt;       done_r <= done_nxt;
      strap_r <= strap_nxt;   io_lat_r <= io_lat_nxt; pp_lat_r <= pp_lat_nxt;
      pull_r <= pull_nxt;     rd_act_r <= rd_act_nxt;
      standby_r <= (state_nxt == PXA_IDLE);
    end
  end

  // =====================================================================
  // transition detection
  logic [7:0] snap_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] hold_nxt;
  logic [7:0] diff;
  logic [7:0] wr_mask;
  logic       int_n_r, int_n_nxt;
  logic       sw_clr;
  logic [7:0] quiet_r, quiet_nxt;
  logic [1:0] settle_r, settle_nxt;

  // ports rewritten by the bus are not compared until the pin level has settled
  assign diff    = (io_live ^ snap_r) & io_lat_r & ~quiet_r;
  assign wr_mask = io_lat_r ^ sh_r;

  // snapshot, sticky flags and latched interrupt
  always_comb begin
    snap_nxt   = snap_r;
    hold_nxt   = hold_r;
    quiet_nxt  = quiet_r;
    settle_nxt = settle_r;
    flags_nxt = flags_r | diff;
    if (ack_evt || sw_clr) begin
      snap_nxt  = io_live;
      flags_nxt = 8'h00;
      hold_nxt  = flags_r | diff;
    end else if (wr_io) begin
      snap_nxt  = (snap_r & ~wr_mask) | (sh_r & wr_mask);
    end else begin
      // written ports follow the pin while the new level crosses the synchroniser
      snap_nxt  = (snap_r & ~quiet_r) | (io_live & quiet_r);
    end
    if (wr_io) begin
      quiet_nxt  = wr_mask;
      settle_nxt = `PXA_WR_SETTLE;
    end else if (settle_r != 2'h0) begin
      settle_nxt = settle_r - 2'h1;
    end else begin
      quiet_nxt  = 8'h00;
    end
    int_n_nxt = ~(|flags_r) | rd_act_r;
  end

  // detection registers, touched only by power-up reset
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      snap_r  <= 8'hFF;
      flags_r <= 8'h00;
      hold_r  <= 8'h00;
      int_n_r <= 1'b1;
      quiet_r  <= 8'h00;
      settle_r <= 2'h0;
    end else begin
      quiet_r  <= quiet_nxt;
      settle_r <= settle_nxt;
      snap_r  <= snap_nxt;
      flags_r <= flags_nxt;
      hold_r  <= hold_nxt;
      int_n_r <= int_n_nxt;
    end
  end

  // =====================================================================
  // wishbone slave
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic        ctrl_en_nxt;
  logic        wb_wr;

  assign wb_wr  = CYC_I & STB_I & WE_I & ack_r & (ADR_I == `PXA_REG_CTRL) & SEL_I[0];
  assign sw_clr = wb_wr & DAT_I[`PXA_CTRL_CLR_BIT];

  // single-wait answer; writes land on the edge that sees ack
  always_comb begin
    ack_nxt     = CYC_I & STB_I & ~ack_r;
    ctrl_en_nxt = wb_wr ? DAT_I[`PXA_CTRL_EN_BIT] : ctrl_en_r;
    dat_nxt     = 32'h0000_0000;
    if (ack_nxt && !WE_I) begin
      unique case (ADR_I)
        `PXA_REG_CTRL:   dat_nxt[`PXA_CTRL_EN_BIT] = ctrl_en_r;
        `PXA_REG_STATUS: dat_nxt = {8'h00, done_r, ~int_n_r, standby_r, 1'b0,
                                    sel_r, 1'b0, pp_addr, 1'b0, io_addr};
        `PXA_REG_PORTS:  dat_nxt = {pp_lat_r, io_lat_r, snap_r, flags_r};
        default:         dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ack_r     <= 1'b0;
      dat_r     <= 32'h0000_0000;
      ctrl_en_r <= `PXA_CTRL_RST;
    end else begin
      ack_r     <= ack_nxt;
      dat_r     <= dat_nxt;
      ctrl_en_r <= ctrl_en_nxt;
    end
  end

  // =====================================================================
  // outputs
  assign ACK_O                  = ack_r;
  assign DAT_O                  = dat_r;
  assign SDA_O                  = 1'b0;
  assign SDA_OE                 = sda_oe_r;
  assign OPEN_DRAIN_IO_PORTS_O  = '0;
  assign OPEN_DRAIN_IO_PORTS_OE = ~io_lat_r;
  assign PUSH_PULL_OUTPUTS      = pp_lat_r;
  assign PULLUP_EN              = pull_r;
  assign INT_N                  = int_n_r;
  assign STANDBY                = standby_r;

  // =====================================================================
  // checks
  sequence first_fall_s;
    link_ok && !start && !stop && pend_r && fall && !done_r;
  endsequence

  sequence flag_read_s;
    link_ok && !start && !stop && state_r == PXA_RACK && fall && grp_io_r && bsel_r;
  endsequence

  bus_reset_idle_a: assert property (@(posedge CLK) disable iff (!rst_n)
    !bus_rst_n |=> state_r == PXA_IDLE && !sda_oe_r) else $error("bus reset left link busy");
  reset_keeps_flags_a: assert property (@(posedge CLK) disable iff (!rst_n)
    !link_ok && !sw_clr |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("bus reset disturbed flags");
  idle_standby_a: assert property (@(posedge CLK) disable iff (!rst_n)
    standby_r == (state_r == PXA_IDLE)) else $error("standby not tracking idle");
  decode_done_a: assert property (@(posedge CLK) disable iff (!rst_n)
    link_ok && !start && !stop && pend_r && fall |=> !pend_r && sel_r == $past(dec))
    else $error("select decode missed");
  addr_prefix_a: assert property (@(posedge CLK) disable iff (!rst_n)
    io_addr[6:4] == 3'h6 && pp_addr[6:4] == 3'h5 && io_addr[3:0] == pp_addr[3:0])
    else $error("slave address prefix wrong");
  strap_high_a: assert property (@(posedge CLK) disable iff (!rst_n)
    !done_r && strap_r == 2'h3 |-> sel_r.hi inside {PXA_SEL_LOW, PXA_SEL_HIGH}
      && sel_r.lo inside {PXA_SEL_LOW, PXA_SEL_HIGH}) else $error("strap decode not two-level");
  first_pullup_a: assert property (@(posedge CLK) disable iff (!rst_n)
    first_fall_s |=> done_r && pull_r == {{4{sel_r.hi != PXA_SEL_LOW}}, {4{sel_r.lo != PXA_SEL_LOW}}})
    else $error("pullups not set from first decode");
  snapshot_load_a: assert property (@(posedge CLK) disable iff (!rst_n)
    ack_evt |=> snap_r == $past(io_live) && flags_r == 8'h00) else $error("snapshot not loaded");
  flag_sticky_a: assert property (@(posedge CLK) disable iff (!rst_n)
    !ack_evt && !sw_clr |=> flags_r == ($past(flags_r) | $past(diff))) else $error("flag lost");
  int_follow_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (|flags_r) && !rd_act_r |=> !INT_N) else $error("interrupt not asserted");
  second_byte_a: assert property (@(posedge CLK) disable iff (!rst_n)
    flag_read_s |=> sh_r == $past(hold_r) && state_r == PXA_RD) else $error("flag byte wrong");
  write_quiet_a: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_io && !sw_clr |=> (snap_r & $past(wr_mask)) == ($past(sh_r) & $past(wr_mask)))
    else $error("written port left in snapshot");
endmodule // pxa_top

// [logic/pxa_cfg.svh]
/*
  constants of the port expander address and change-detect block.
  assumes it is included by its bare name after the package.
*/
// =====================================================================
// Function
// - reset pin aborts any serial transfer; interface returns to idle
// - reset pin leaves interrupt and transition flags untouched
// - idle serial interface means standby, left on bus activity
// - slave address re-decoded on every transmission, addressed or not
// - each select pin decoded as low, high, data line or clock line
// - new select wiring takes effect at next decoded transmission
// - before first transmission, data or clock ties count as high
// - first select pin sets ports 0-3, second sets ports 4-7
// - high, data or clock decode: pullups on, default high; low: off, low
// - pullups and defaults corrected at the first transmission on the bus
// - io address 110, bits 3-2 from second pin, bits 1-0 from first pin
// - push-pull address 101, same low bits; pins set output defaults
// - input ports watched for change since the last serial access
// - snapshot compared with live inputs; mismatch asserts interrupt
// - acknowledge of each access loads snapshot and clears flags
// - second byte of an io read returns flags held before the clear; push-pull reads return the readback
// - port changes made by a serial write raise no interrupt
// - each input change sets its own one of eight flag bits
// - power-up clears flags and deasserts the interrupt
`ifndef PXA_CFG_SVH
`define PXA_CFG_SVH

// =====================================================================
// slave address prefixes
`define PXA_IO_PREFIX    3'h6
`define PXA_PP_PREFIX    3'h5

// =====================================================================
// register byte offsets and fields
`define PXA_REG_CTRL     8'h00
`define PXA_REG_STATUS   8'h04
`define PXA_REG_PORTS    8'h08
`define PXA_CTRL_EN_BIT  0
`define PXA_CTRL_CLR_BIT 1
`define PXA_CTRL_RST     1'h1

// =====================================================================
// timing counts
`define PXA_STRAP_WAIT   2'h3
`define PXA_BYTE_BITS    4'h8
`define PXA_WR_SETTLE    2'h3

`endif

// [logic/pxa_pkg.sv]
/*
  types of the port expander address and change-detect block.
  assumes nothing of its surroundings.
*/
package pxa_pkg;
  // =====================================================================
  // four-level select decode
  typedef enum logic [1:0] {PXA_SEL_LOW, PXA_SEL_HIGH, PXA_SEL_SDA, PXA_SEL_SCL} pxa_sel_type;

  // both select pins travel together
  typedef struct packed {
    pxa_sel_type hi;
    pxa_sel_type lo;
  } pxa_selpair_type;

  // serial interface states
  typedef enum logic [2:0] {
    PXA_IDLE, PXA_SKIP, PXA_ADDR, PXA_AACK, PXA_WR, PXA_WACK, PXA_RD, PXA_RACK
  } pxa_state_type;
endpackage : pxa_pkg

// [logic/pxa_sync.sv]
/*
  two-flop synchroniser for inputs from outside the clock domain.
  assumes an asynchronous active-low reset; idle level is high.
*/
module pxa_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '1;
      q_r    <= '1;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule // pxa_sync

// [tb/pxa_i2c_master.sv]
/*
  two-wire bus master model: start, stop, byte out, byte in.
  assumes sda_in is the resolved wire with a pull-up and clk is 100 ns.
*/
module pxa_i2c_master (
  // clock
  input  wire logic clk,
  // bus lines
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  // lines idle high, scl stands still outside frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // quarter of the 800 ns link period
  task automatic qw(input int n);
    repeat (2 * n) @(posedge clk);
  endtask
  // drive one bit, sample the wire in the high phase
  task automatic bit_x(input logic b, output logic r);
    sda_drv <= b;
    qw(1);
    scl <= 1'b1;
    qw(1);
    r = sda_in;
    qw(1);
    scl <= 1'b0;
    qw(1);
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    scl <= 1'b1;
    qw(1);
    sda_drv <= 1'b0;
    qw(1);
    scl <= 1'b0;
    qw(1);
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    qw(1);
    scl <= 1'b1;
    qw(1);
    sda_drv <= 1'b1;
    qw(2);
  endtask
  // msb first, ninth bit released for the slave
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], ack);
    bit_x(1'b1, ack);
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(mack, r);
  endtask
endmodule // pxa_i2c_master

// [tb/test_port_expander_addr_and_change_detect.sv]
/*
  bench: select pins, power-up defaults, change flags, link abort.
  assumes low select pin tied to scl and high select pin bench driven.
*/
module test_port_expander_addr_and_change_detect;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic bus_rst_n = 1'b1, hi_pin = 1'b0, ack, sda_oe, int_n, standby, scl, m_sda;
  logic [7:0] adr = 8'h00, ext = 8'hFF, io_oe, pp_out, pu_en;
  logic [31:0] dat_w = 32'h0000_0000, dat_r;
  int num_errors = 0, n_tests = 0;
  // open-drain wires with pull-ups
  wire sda = m_sda & ~sda_oe;
  wire [7:0] io_in = ext & ~io_oe;
  always #50 clk = ~clk;
  pxa_i2c_master m_u (.clk(clk), .sda_in(sda), .scl(scl), .sda_drv(m_sda));
  pxa_top dut_u (.CLK(clk), .ARST_N(arst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe), .BUS_RST_N(bus_rst_n),
    .ADDR_SELECT_LOW_PIN(scl), .ADDR_SELECT_HIGH_PIN(hi_pin),
    .OPEN_DRAIN_IO_PORTS_I(io_in), .OPEN_DRAIN_IO_PORTS_O(), .OPEN_DRAIN_IO_PORTS_OE(io_oe),
    .PUSH_PULL_OUTPUTS(pp_out), .PUSH_PULL_READBACK(pp_out), .PULLUP_EN(pu_en),
    .INT_N(int_n), .STANDBY(standby));
  // ==================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= 32'h0000_0000;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    chk(n, 32'h2);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // register write: data set with the request, held until ack
  task automatic wb_w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b1;
    adr <= a;
    dat_w <= d;
    do @(posedge clk);
    while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  // ==================================================================
  // tests
  initial begin
    logic [31:0] q;
    logic a;
    logic [7:0] b;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk({14'h0, pu_en, pp_out, int_n, standby}, 32'h0000_3C3F);
    m_u.start();
    m_u.wr_byte(8'h22, a);
    m_u.stop();
    wb(1'b0, 8'h04, q);
    chk(q & 32'h008F_7F7F, 32'h0083_5A6A);
    chk({20'h0, pu_en, pp_out[3:0]}, 32'h0000_00FF);
    ext <= 8'hFD;
    repeat (8) @(posedge clk);
    ext <= 8'hFF;
    repeat (8) @(posedge clk);
    chk({31'h0, int_n}, 32'h0);
    wb(1'b0, 8'h08, q);
    chk(q & 32'h0000_00FF, 32'h0000_0002);
    m_u.start();
    m_u.wr_byte(8'h22, a);
    chk({31'h0, standby}, 32'h0);
    bus_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk({29'h0, sda_oe, standby, int_n}, 32'h0000_0002);
    m_u.stop();
    bus_rst_n <= 1'b1;
    wb(1'b0, 8'h08, q);
    chk(q & 32'h0000_00FF, 32'h0000_0002);
    m_u.start();
    m_u.wr_byte(8'hD5, a);
    chk({31'h0, a}, 32'h0);
    m_u.rd_byte(1'b0, b);
    chk({24'h0, b}, 32'h0000_000F);
    m_u.rd_byte(1'b1, b);
    chk({24'h0, b}, 32'h0000_0002);
    m_u.stop();
    wb(1'b0, 8'h08, q);
    chk({16'h0, q[7:0], 7'h0, int_n}, 32'h0000_0001);
    m_u.start();
    m_u.wr_byte(8'hD4, a);
    m_u.wr_byte(8'hF0, a);
    m_u.stop();
    repeat (8) @(posedge clk);
    chk({16'h0, io_oe, 7'h0, int_n}, 32'h0000_0F01);
    m_u.start();
    m_u.wr_byte(8'hB4, a);
    m_u.wr_byte(8'hA5, a);
    m_u.stop();
    chk({23'h0, a, pp_out}, 32'h0000_00A5);
    m_u.start();
    m_u.wr_byte(8'hB5, a);
    m_u.rd_byte(1'b1, b);
    m_u.stop();
    chk({23'h0, a, b}, 32'h0000_00A5);
    hi_pin <= 1'b1;
    m_u.start();
    m_u.wr_byte(8'h22, a);
    m_u.stop();
    wb(1'b0, 8'h04, q);
    chk(q & 32'h008F_7F7F, 32'h0087_5E6E);
    wb(1'b0, 8'h0C, q);
    chk(q, 32'h0000_0000);
    ext <= 8'hEF;
    repeat (8) @(posedge clk);
    ext <= 8'hFF;
    repeat (8) @(posedge clk);
    chk({31'h0, int_n}, 32'h0);
    wb_w(8'h00, 32'h0000_0003);
    wb(1'b0, 8'h08, q);
    chk({q[15:0], 15'h0, int_n}, 32'hF000_0001);
    wb_w(8'h00, 32'h0000_0000);
    m_u.start();
    m_u.wr_byte(8'hBD, a);
    m_u.stop();
    chk({31'h0, a}, 32'h1);
    wb(1'b0, 8'h00, q);
    chk(q, 32'h0000_0000);
    wb_w(8'h00, 32'h0000_0001);
    m_u.start();
    m_u.wr_byte(8'hBD, a);
    m_u.rd_byte(1'b1, b);
    m_u.stop();
    chk({23'h0, a, b}, 32'h0000_00A5);
    print_verdict();
  end
endmodule // test_port_expander_addr_and_change_detect
